// ==== logic/two_way_handshake_pkg.sv ====
// constants, types and state layout of the two-way handshake port
package two_way_handshake_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int DELAY_STEP_NS = 100;
  localparam int DELAY_MAX_NS = 700;
  localparam int DELAY_STEP_CYC =
    (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOA_MIN_NS = 25;
  localparam int DOA_RAW_CYC =
    (DOA_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOA_CYC = (DOA_RAW_CYC < 1) ? 1 : DOA_RAW_CYC;
  localparam int REQ_OFF_DO_NS = 50;
  localparam int REQ_OFF_DO_RAW = REQ_OFF_DO_NS / CLK_PERIOD_NS;
  localparam int REQ_OFF_DO_CYC = (REQ_OFF_DO_RAW < 1) ? 1 : REQ_OFF_DO_RAW;
  localparam int CNT_W = 4;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DOUT_OFS = 8'h04;
  localparam logic [7:0] DIN_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // control field positions, matching cfg_t
  localparam int EN_BIT = 0;
  localparam int EMUL_BIT = 1;
  localparam int DIR_BIT = 2;
  localparam int WIDTH_LSB = 3;
  localparam int ACK_POL_BIT = 5;
  localparam int REQ_POL_BIT = 6;
  localparam int LATCH_BIT = 7;
  localparam int DELAY_LSB = 8;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;

  // status field positions
  localparam int STS_ACK_BIT = 0;
  localparam int STS_IN_FULL_BIT = 1;
  localparam int STS_OUT_PEND_BIT = 2;
  localparam int STS_STATE_LSB = 4;

  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] delay;
    logic latch;
    logic req_pol;
    logic ack_pol;
    logic [1:0] width;
    logic dir_out;
    logic emul;
    logic en;
  } cfg_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_ACK = 4'b0100,
    ST_WAIT_END = 4'b1000
  } hs_state_t;

  typedef struct packed {
    logic ack;
    logic ack_oe_n;
    logic [31:0] data;
    logic data_oe_n;
  } pin_out_t;

  typedef struct packed {
    cfg_t cfg;
    hs_state_t st;
    logic [CNT_W-1:0] cnt;
    logic [2:0] req_sync;
    logic in_full;
    logic out_pend;
    logic [31:0] in_word;
    logic [31:0] out_word;
    pin_out_t pins;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic dp_wr;
    logic [7:0] dp_addr;
  } state_t;

endpackage

// ==== logic/two_way_handshake_port.sv ====
// two-way handshake engine for a parallel port, with an AHB-Lite slave
// ----------------------------------------------------------------
// How it works
// [RULE_01] ack shows device readiness, request peripheral readiness
// [RULE_02] emulation data path 8, 16 or 32 bits
// [RULE_03] optional settling delay between emulation transfers
// [RULE_04] emulation input: ack low when ready
// [RULE_05] peripheral strobes request low then high
// [RULE_06] falling request releases ack, rising captures data
// [RULE_07] ack low again only when ready again
// [RULE_08] emulation output: ack low once data valid
// [RULE_09] peripheral takes data between ack edges
// [RULE_10] request fall releases ack, rise allows next
// [RULE_11] peripheral holds request low until data taken
// [RULE_12] level mode: ack and request polarity configurable
// [RULE_13] delay 0 to 700 ns in 100 ns steps
// [RULE_14] input latching registers connector data at request edge
// [RULE_15] output latching updates connector register at request edge
// [RULE_16] level mode: ack held until active request edge
// [RULE_17] level input: active edge drops ack, captures word
// [RULE_18] level mode: delay inserted before ack
// [RULE_19] level output: data first, then ack
// [RULE_20] peripheral answers with active request edge
// [RULE_21] data valid 25 ns plus delay before ack
// [RULE_22] latched output word within 50 ns of release; the code updates it 200 to 300 ns later
// [RULE_23] request synchronised, edges from synchronised copy
// ----------------------------------------------------------------
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module two_way_handshake_port
  import two_way_handshake_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic [31:0] hrdata,
  output var logic hreadyout,
  output var logic hresp,
  input wire logic req_i,
  input wire logic [31:0] data_i,
  output var pin_out_t pins_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] width_mask(input logic [1:0] w);
    if (w == WIDTH_8) begin
      return 32'h0000_00FF;
    end else if (w == WIDTH_16) begin
      return 32'h0000_FFFF;
    end else begin
      return 32'hFFFF_FFFF;
    end
  endfunction

  // cycles spent in settle before ack; output adds the data setup time
  function automatic logic [CNT_W-1:0] settle_len(input cfg_t c);
    int n;
    n = int'(c.delay) * DELAY_STEP_CYC;
    if (c.dir_out) begin
      n = n + DOA_CYC;
    end
    return CNT_W'(n);
  endfunction

  state_t r;
  state_t n;
  logic ack_lvl;
  logic ack_on_lvl;
  logic req_lvl;
  logic rq_on;
  logic rq_off;
  logic [31:0] mask;
  logic in_set;
  logic rd_clr;
  logic out_set;
  logic out_clr;
  logic [CNT_W-1:0] len;
  logic [31:0] sts;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    in_set = 1'b0;
    rd_clr = 1'b0;
    out_set = 1'b0;
    out_clr = 1'b0;
    // emulation fixes both lines active low; level mode uses the pols
    ack_lvl = r.cfg.emul ? 1'b0 : r.cfg.ack_pol; // [RULE_04] [RULE_12]
    req_lvl = r.cfg.emul ? 1'b0 : r.cfg.req_pol; // [RULE_12]
    mask = width_mask(r.cfg.width); // [RULE_02]
    len = settle_len(r.cfg);
    // bit 0 is read only by bit 1; edges come from bits 1 and 2
    n.req_sync = {r.req_sync[1:0], req_i}; // [RULE_23]
    rq_on = (r.req_sync[1] == req_lvl)
      && (r.req_sync[2] != req_lvl); // [RULE_23]
    rq_off = (r.req_sync[1] != req_lvl)
      && (r.req_sync[2] == req_lvl); // [RULE_23]

    sts = 32'h0000_0000;
    sts[STS_ACK_BIT] = (r.st == ST_ACK);
    sts[STS_IN_FULL_BIT] = r.in_full;
    sts[STS_OUT_PEND_BIT] = r.out_pend;
    sts[STS_STATE_LSB +: 4] = r.st;

    // bus data phase: writes land here with hwdata
    n.dp_wr = 1'b0;
    if (r.dp_wr) begin
      if (r.dp_addr == CTRL_OFS) begin
        n.cfg = cfg_t'(hwdata[CTRL_W-1:0]);
      end else if (r.dp_addr == DOUT_OFS) begin
        n.out_word = hwdata;
        out_set = 1'b1;
      end
    end

    // bus address phase; read data is ready for the data phase
    if (hsel && htrans[1] && hready) begin
      n.dp_wr = hwrite;
      n.dp_addr = haddr[7:0];
      if (!hwrite) begin
        if (haddr[7:0] == CTRL_OFS) begin
          n.hrdata = {{(32 - CTRL_W){1'b0}}, r.cfg};
        end else if (haddr[7:0] == DOUT_OFS) begin
          n.hrdata = r.out_word;
        end else if (haddr[7:0] == DIN_OFS) begin
          n.hrdata = r.in_word;
          rd_clr = 1'b1;
        end else if (haddr[7:0] == STATUS_OFS) begin
          n.hrdata = sts;
        end else begin
          n.hrdata = 32'h0000_0000;
        end
      end
    end

    // ----------------------------------------------------------------
    // handshake engine
    // ----------------------------------------------------------------
    if (!r.cfg.en) begin
      n.st = ST_IDLE;
      n.cnt = '0;
    end else begin
      case (r.st)
        ST_IDLE: begin
          if (r.cfg.dir_out) begin
            if (r.out_pend) begin
              // word goes on the pins before the setup count starts
              n.pins.data = r.out_word & mask; // [RULE_19] [RULE_08]
              out_clr = 1'b1;
              n.st = ST_SETTLE;
              n.cnt = len - CNT_W'(1); // [RULE_21] [RULE_18]
            end
          end else if (!r.in_full) begin
            // a full input word blocks ack until software reads it
            if (len == '0) begin // [RULE_07]
              n.st = ST_ACK;
            end else begin
              n.st = ST_SETTLE;
              n.cnt = len - CNT_W'(1); // [RULE_03] [RULE_13] [RULE_18]
            end
          end
        end
        ST_SETTLE: begin
          if (r.cnt == '0) begin
            n.st = ST_ACK; // [RULE_16]
          end else begin
            n.cnt = r.cnt - CNT_W'(1); // [RULE_13]
          end
        end
        ST_ACK: begin
          // ack stands until the request turns active
          if (rq_on) begin
            n.st = ST_WAIT_END; // [RULE_06] [RULE_10] [RULE_16]
            if (!r.cfg.emul && !r.cfg.dir_out) begin
              n.in_word = data_i & mask; // [RULE_17] [RULE_14]
              in_set = 1'b1;
            end
          end
        end
        ST_WAIT_END: begin
          // the next transfer may only start once the request is released
          if (rq_off) begin
            n.st = ST_IDLE; // [RULE_10]
            if (r.cfg.emul && !r.cfg.dir_out) begin
              n.in_word = data_i & mask; // [RULE_06] [RULE_14]
              in_set = 1'b1;
            end
            if (r.cfg.dir_out && r.cfg.latch && r.out_pend) begin
              // connector register follows the release edge directly
              n.pins.data = r.out_word & mask; // [RULE_15] [RULE_22]
              out_clr = 1'b1;
              n.st = ST_SETTLE;
              n.cnt = len - CNT_W'(1);
            end
          end
        end
        default: begin
          n.st = ST_IDLE;
        end
      endcase
    end

    // a set in the same cycle as its clear wins
    n.in_full = in_set | (r.in_full & ~rd_clr);
    n.out_pend = out_set | (r.out_pend & ~out_clr);

    // ack asserted only while the device waits in the ack state
    // polarity of the coming cycle, so a control write never flashes ack
    ack_on_lvl = n.cfg.emul ? 1'b0 : n.cfg.ack_pol; // [RULE_12]
    n.pins.ack = (n.st == ST_ACK) ? ack_on_lvl : ~ack_on_lvl; // [RULE_01]
    n.pins.ack_oe_n = ~n.cfg.en;
    n.pins.data_oe_n = ~(n.cfg.en & n.cfg.dir_out);
    n.hreadyout = 1'b1;
    n.hresp = 1'b0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.cfg <= cfg_t'(CTRL_RESET);
      r.st <= ST_IDLE;
      r.pins.ack <= 1'b1;
      r.pins.ack_oe_n <= 1'b1;
      r.pins.data_oe_n <= 1'b1;
      r.hreadyout <= 1'b1;
    end else if (ce) begin
      r <= n;
    end
  end

  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign pins_o = r.pins;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn || !ce);

  sequence s_settle_in2;
    $rose(r.st == ST_SETTLE) && !r.cfg.dir_out && r.cfg.delay == 3'h2;
  endsequence

  sequence s_emul_end_in;
    r.cfg.en && r.cfg.emul && !r.cfg.dir_out && r.st == ST_WAIT_END && rq_off;
  endsequence

  a_ack_meaning: assert property ( // [RULE_01]
    (pins_o.ack == ack_lvl) && r.cfg.en |-> r.st == ST_ACK)
    else $error("ack active outside the ack state");

  a_width_mask: assert property ( // [RULE_02]
    r.cfg.width == WIDTH_8 && r.cfg.en && $changed(pins_o.data)
    |-> pins_o.data[31:8] == 24'h000000)
    else $error("data above 8-bit width not zero");

  a_settle_len: assert property ( // [RULE_13]
    s_settle_in2 |-> ##1 r.st == ST_SETTLE ##1 r.st == ST_ACK)
    else $error("settle delay length wrong");

  a_emul_ack_low: assert property ( // [RULE_04]
    r.cfg.emul && r.cfg.en && r.st == ST_ACK |-> pins_o.ack == 1'b0)
    else $error("emulation ack not low when ready");

  a_ack_release: assert property ( // [RULE_06]
    r.cfg.en && r.st == ST_ACK && rq_on
    |=> r.st == ST_WAIT_END && pins_o.ack != ack_lvl)
    else $error("ack not released on request edge");

  a_emul_capture: assert property ( // [RULE_06]
    s_emul_end_in
    |=> r.in_full && r.in_word == ($past(data_i) & $past(mask)))
    else $error("emulation input word not captured");

  a_full_no_ack: assert property ( // [RULE_07]
    r.cfg.en && !r.cfg.dir_out && r.in_full && r.st == ST_IDLE
    |=> r.st == ST_IDLE)
    else $error("ack offered while input word unread");

  a_out_setup: assert property ( // [RULE_21]
    r.cfg.en && r.cfg.dir_out && $rose(r.st == ST_ACK)
    |-> $stable(pins_o.data) && $past(r.st) == ST_SETTLE)
    else $error("output data not settled before ack");

  a_level_pol: assert property ( // [RULE_12]
    !r.cfg.emul && r.cfg.en && r.st == ST_ACK
    |-> pins_o.ack == r.cfg.ack_pol)
    else $error("level mode ack polarity wrong");

endmodule
`default_nettype wire

// ==== test/peripheral_model.sv ====
// peripheral model: answers ack with a request strobe and swaps words
`timescale 1ns/1ps
`default_nettype none
module peripheral_model
  import two_way_handshake_pkg::*;
(
  input wire logic hclk,
  input wire logic run,
  input wire logic ack_hi,
  input wire logic req_hi,
  input wire logic [4:0] hold,
  input wire pin_out_t pins,
  output logic req,
  output logic [31:0] dval,
  output logic [31:0] got,
  output int n_got,
  output int setup,
  output int drop
);
  logic act = 1'b0;
  logic [31:0] last = 32'h0;
  int since = 0;
  wire logic ack_on;
  assign ack_on = !pins.ack_oe_n && pins.ack === ack_hi;
  assign req = act ? req_hi : !req_hi;
  // cycles the output word has been stable, for the setup figure
  always @(posedge hclk) begin
    since <= (pins.data !== last) ? 1 : since + 1;
    last <= pins.data;
  end
  initial begin
    dval = 32'h0;
    got = 32'h0;
    n_got = 0;
    setup = 0;
    drop = 0;
    forever begin
      @(posedge hclk);
      if (run && ack_on) begin
        setup = since;
        got = pins.data;
        repeat (hold) @(posedge hclk);
        dval <= 32'hC35A_96F0 + n_got;
        act <= 1'b1;
        drop = 0;
        while (ack_on && drop < 40) begin
          @(posedge hclk);
          drop++;
        end
        repeat (2) @(posedge hclk);
        act <= 1'b0;
        repeat (5) @(posedge hclk);
        // released lines must not look like the last word
        dval <= ~dval;
        n_got <= n_got + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/two_way_handshake_port_tb.sv ====
// self-checking bench for the two-way handshake port
`timescale 1ns/1ps
`default_nettype none
module two_way_handshake_port_tb import two_way_handshake_pkg::*;;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, dval, got;
  logic hreadyout, hresp, req;
  pin_out_t pins_o;
  logic run = 1'b0;
  logic ack_hi = 1'b0;
  logic req_hi = 1'b0;
  logic [4:0] hold = 5'h00;
  int n_got, setup, drop;
  int bad_count = 0;
  int checked = 0;
  always #50 hclk = ~hclk;
  two_way_handshake_port i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .req_i(req), .data_i(dval),
    .pins_o(pins_o));
  peripheral_model i_peer (.hclk(hclk), .run(run), .ack_hi(ack_hi),
    .req_hi(req_hi), .hold(hold), .pins(pins_o), .req(req), .dval(dval),
    .got(got), .n_got(n_got), .setup(setup), .drop(drop));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic next_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      bad_count++;
      complete_run();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    next_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    next_ready();
    r = hrdata;
  endtask
  task automatic wait_peer(input int n0);
    int k;
    k = 0;
    while (n_got == n0 && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 400) begin
      bad_count++;
      complete_run();
    end
  endtask
  function automatic logic [31:0] msk(input logic [1:0] wd,
                                      input logic [31:0] v);
    if (wd == WIDTH_8)
      return v & 32'h0000_00FF;
    return (wd == WIDTH_16) ? v & 32'h0000_FFFF : v;
  endfunction
  // polarity is switched only while disabled, so no false edge is seen
  task automatic xfer(input logic [10:0] c, input logic [31:0] w,
                      input logic ah, input logic rh, output logic [31:0] r);
    int n0;
    n0 = n_got;
    bus(1'b1, CTRL_OFS, 32'h0, r);
    ack_hi <= ah;
    req_hi <= rh;
    repeat (4) @(posedge hclk);
    bus(1'b1, CTRL_OFS, {21'h0, c}, r);
    if (c[DIR_BIT])
      bus(1'b1, DOUT_OFS, w, r);
    run <= 1'b1;
    wait_peer(n0);
    run <= 1'b0;
    r = got;
    if (!c[DIR_BIT]) begin
      repeat (4) @(posedge hclk);
      chk({31'h0, pins_o.ack}, {31'h0, !ack_hi});
      bus(1'b0, DIN_OFS, 32'h0, r);
    end
  endtask
  task automatic t_reset;
    logic [31:0] r;
    chk({29'h0, pins_o.ack, pins_o.ack_oe_n, pins_o.data_oe_n},
        32'h7);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    bus(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, {21'h0, CTRL_RESET});
    bus(1'b0, STATUS_OFS, 32'h0, r);
    chk(r, 32'h0000_0010);
    bus(1'b0, 8'h10, 32'h0, r);
    chk(r, 32'h0);
    // a write made while the clock enable is low must not land
    ce <= 1'b0;
    bus(1'b1, CTRL_OFS, 32'h0000_0005, r);
    ce <= 1'b1;
    bus(1'b0, CTRL_OFS, 32'h0, r);
    chk(r, {21'h0, CTRL_RESET});
    $display("reset test done");
  endtask
  task automatic t_emul_in;
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      // delay follows i, so the input settle path is walked too
      xfer({1'b0, i[1:0], 3'h0, i[1:0], 3'b011}, 32'h0, 1'b0, 1'b0, r);
      chk(r, msk(i[1:0], 32'hC35A_96F0 + n_got - 1));
      chk(drop, 4);
    end
    $display("emulation input test done");
  endtask
  task automatic t_emul_out;
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      xfer({i[2:0] * 3'h3, 3'b000, i[1:0], 3'b111}, 32'h8E17_A4D2 ^ i,
           1'b0, 1'b0, r);
      chk(r, msk(i[1:0], 32'h8E17_A4D2 ^ i));
      chk(setup >= i * 3 + 1, 1);
    end
    $display("emulation output test done");
  endtask
  task automatic t_level_in;
    logic [31:0] r;
    for (int p = 0; p < 4; p++) begin
      xfer({3'h0, p[0], p[1], p[0], 5'h11}, 32'h0, p[0], p[1], r);
      chk(r, 32'hC35A_96F0 + n_got - 1);
      chk(drop, 4);
    end
    $display("level input test done");
  endtask
  task automatic t_level_out;
    logic [31:0] r;
    for (int i = 0; i < 2; i++) begin
      xfer({i[0] ? 3'h7 : 3'h0, 8'h75}, 32'h6B2D_19E4 + i, 1'b1, 1'b1, r);
      chk(r, 32'h6B2D_19E4 + i);
      chk(setup >= (i ? 8 : 1), 1);
    end
    $display("level output test done");
  endtask
  // a slow peer leaves room to queue the next word during the transfer
  task automatic t_latch_out;
    logic [31:0] r;
    int n0;
    n0 = n_got;
    hold <= 5'h14;
    bus(1'b1, CTRL_OFS, 32'h0000_00F5, r);
    bus(1'b1, DOUT_OFS, 32'h1357_9BDF, r);
    run <= 1'b1;
    repeat (10) @(posedge hclk);
    chk(got, 32'h1357_9BDF);
    bus(1'b1, DOUT_OFS, 32'h2468_ACE0, r);
    chk(pins_o.data, 32'h1357_9BDF);
    wait_peer(n0);
    run <= 1'b0;
    chk(pins_o.data, 32'h2468_ACE0);
    $display("latched output test done");
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_emul_in();
    t_emul_out();
    t_level_in();
    t_level_out();
    t_latch_out();
    complete_run();
  end
endmodule
`default_nettype wire
